// ---- rtl/cdseq_top.v ----
// Function
// [RULE1] single zero calibrates current range, input shorted
// [RULE2] samples 25..4000, interval bounded, defaults replaceable
// [RULE3] controller enables calibration before zero requests
// [RULE4] controller selects range and filter first
// [RULE5] all-range zero walks ranges, zero means pass
// [RULE6] failure bitmask, bit equals range index
// [RULE7] failed range recorded, sequence continues
// [RULE8] error report names highest failed range
// [RULE9] gain write loads 8-bit code
// [RULE10] gain code scales full-scale output linearly
// [RULE11] stored offset applied at next gain write
// [RULE12] offset ramp steps 0..255 each 100us
// [RULE13] offset ramp count 1..32767, exact ramps
// [RULE14] source level drives calibration bus converter
// [RULE15] source ramp steps 0..4095 each 100us
// [RULE16] source ramp count 1..255, exact ramps
// [RULE17] reset forces source converter to zero
// [RULE18] input relay open until enable or reset
// [RULE19] refuse requests while acquisition running
// [RULE20] calibration disabled rejects gain and zero
// [RULE21] ramp ends holding code, signals done
//
// Purpose: calibration and diagnostic converter sequencer, AXI4-Lite slave
// Assumes: single 20 MHz clock, synchronous active-high reset
// Notes:   converter codes are offset binary; mid-code is 0 V
`timescale 1ns/1ps
`default_nettype none
`include "cdseq_map.vh"

module cdseq_top (
    input  wire        CLK_SYS,        // 20 MHz clock
    input  wire        RST,            // sync reset, active high
    input  wire [7:0]  S_AXI_AWADDR,   // write address
    input  wire        S_AXI_AWVALID,  // write address valid
    output wire        S_AXI_AWREADY,  // write address ready
    input  wire [31:0] S_AXI_WDATA,    // write data
    input  wire [3:0]  S_AXI_WSTRB,    // byte strobes
    input  wire        S_AXI_WVALID,   // write data valid
    output wire        S_AXI_WREADY,   // write data ready
    output reg  [1:0]  S_AXI_BRESP,    // write response
    output reg         S_AXI_BVALID,   // write response valid
    input  wire        S_AXI_BREADY,   // write response ready
    input  wire [7:0]  S_AXI_ARADDR,   // read address
    input  wire        S_AXI_ARVALID,  // read address valid
    output wire        S_AXI_ARREADY,  // read address ready
    output reg  [31:0] S_AXI_RDATA,    // read data
    output reg  [1:0]  S_AXI_RRESP,    // read response
    output reg         S_AXI_RVALID,   // read valid
    input  wire        S_AXI_RREADY,   // read ready
    input  wire        ACQ_ACTIVE,     // acquisition initiated
    input  wire        INPUT_ENABLE,   // input-enable command pulse
    input  wire [2:0]  RANGE_SEL,      // currently selected range
    input  wire        ADC_VALID,      // offset sample valid
    input  wire [15:0] ADC_DATA,       // offset sample
    output reg         SHORT_EN,       // internal short on input
    output reg  [2:0]  CAL_RANGE,      // range forced during calibration
    output reg         CAL_RANGE_OVR,  // range override active
    output reg  [1:0]  CAL_CHAN,       // channel addressed
    output reg  [7:0]  GAIN_CODE,      // gain converter code
    output reg  [7:0]  OFS_CODE,       // offset converter code
    output reg  [3:0]  CONV_LOAD,      // per-channel converter load pulse
    output reg  [11:0] SRC_CODE,       // calibration-source converter code
    output reg         RELAY_CLOSED    // channel input relay closed
);
    // ==
    // states
    localparam [4:0] ST_IDLE = 5'b00001;
    localparam [4:0] ST_ZERO = 5'b00010;
    localparam [4:0] ST_WAIT = 5'b00100;
    localparam [4:0] ST_ORMP = 5'b01000;
    localparam [4:0] ST_SRMP = 5'b10000;

    reg [4:0]  st_q;
    reg        cal_en_q;
    reg [31:0] arg_q;
    reg [22:0] rate_q;
    reg [15:0] limit_q;
    reg [3:0]  err_q;
    reg [2:0]  err_rng_q;
    reg [5:0]  fail_q;
    reg        all_q;
    reg [2:0]  rng_q;
    reg [15:0] left_q;
    reg        done_q;
    reg [7:0]  ofs_hold_q;
    reg        cmd_go;
    reg [5:0]  cmd_q;
    reg        aw_q, w_q;
    reg [7:0]  awaddr_q;
    reg [31:0] wdata_q;
    reg [3:0]  wstrb_q;

    wire       busy = (st_q != ST_IDLE);
    wire       tick;
    wire       samp_done;
    wire       samp_fail;
    reg        samp_start;
    wire [11:0] samp_n = (arg_q[11:0] == 12'h000) ? `CDSEQ_SAMP_DEF : arg_q[11:0];
    wire [22:0] rate_n = (rate_q == 23'h000000) ? `CDSEQ_RATE_DEF : rate_q;
    wire [31:0] ctrl_m;
    wire [31:0] rate_m;

    // merge byte strobes into an old word
    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0]  be;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (be[i]) merge[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
    endfunction

    assign ctrl_m = merge({limit_q, 16'h0000}, wdata_q, wstrb_q);
    assign rate_m = merge({9'h000, rate_q}, wdata_q, wstrb_q);

    // ==
    // submodules
    cdseq_tick u_tick (
        .clk  (CLK_SYS),
        .rst  (RST),
        .run  (st_q == ST_ORMP || st_q == ST_SRMP),
        .tick (tick)
    );

    cdseq_samp u_samp (
        .clk     (CLK_SYS),
        .rst     (RST),
        .start   (samp_start),
        .samples (samp_n),
        .rate    (rate_n),
        .adc_vld (ADC_VALID),
        .adc_dat (ADC_DATA),
        .limit   (limit_q),
        .done    (samp_done),
        .fail    (samp_fail)
    );

    // ==
    // AXI write: latch address and data in any order, respond once both held
    assign S_AXI_AWREADY = !aw_q && !S_AXI_BVALID;
    assign S_AXI_WREADY  = !w_q && !S_AXI_BVALID;
    assign S_AXI_ARREADY = !S_AXI_RVALID;
    wire   wr_fire = aw_q && w_q && !S_AXI_BVALID;

    always @(posedge CLK_SYS) begin
        cmd_go <= 1'b0;
        if (RST) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= 2'h0;
            cal_en_q <= 1'b0;
            arg_q <= 32'h00000000;
            rate_q <= 23'h000000;
            limit_q <= 16'h0040;
            cmd_q <= 6'h00;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_q <= 1'b1;
                awaddr_q <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_q <= 1'b1;
                wdata_q <= S_AXI_WDATA;
                wstrb_q <= S_AXI_WSTRB;
            end
            if (S_AXI_BVALID && S_AXI_BREADY) S_AXI_BVALID <= 1'b0;
            if (wr_fire) begin
                aw_q <= 1'b0;
                w_q <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= 2'h0;
                case (awaddr_q)
                    `CDSEQ_CTRL_OFF: begin
                        cal_en_q <= wstrb_q[0] ? wdata_q[0] : cal_en_q;
                        limit_q <= ctrl_m[31:16];
                    end
                    `CDSEQ_ARG_OFF:  arg_q <= merge(arg_q, wdata_q, wstrb_q);
                    `CDSEQ_RATE_OFF: rate_q <= rate_m[22:0];
                    `CDSEQ_CMD_OFF: begin
                        cmd_q <= wdata_q[5:0];
                        cmd_go <= 1'b1;
                    end
                    `CDSEQ_STAT_OFF, `CDSEQ_RES_OFF, `CDSEQ_GAIN_OFF,
                    `CDSEQ_OFS_OFF, `CDSEQ_SRC_OFF: S_AXI_BRESP <= 2'h0;
                    default: S_AXI_BRESP <= 2'h2;
                endcase
            end
        end
    end

    // ==
    // AXI read: one-cycle answer from registered data
    always @(posedge CLK_SYS) begin
        if (RST) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h00000000;
            S_AXI_RRESP <= 2'h0;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RRESP <= 2'h0;
            case (S_AXI_ARADDR)
                `CDSEQ_CTRL_OFF: S_AXI_RDATA <= {limit_q, 15'h0000, cal_en_q};
                `CDSEQ_CMD_OFF:  S_AXI_RDATA <= {26'h0000000, cmd_q};
                `CDSEQ_ARG_OFF:  S_AXI_RDATA <= arg_q;
                `CDSEQ_RATE_OFF: S_AXI_RDATA <= {9'h000, rate_q};
                `CDSEQ_STAT_OFF: S_AXI_RDATA <= {17'h00000, err_rng_q, err_q, 6'h00, done_q, busy};
                `CDSEQ_RES_OFF:  S_AXI_RDATA <= {26'h0000000, fail_q}; // RULE6
                `CDSEQ_GAIN_OFF: S_AXI_RDATA <= {24'h000000, GAIN_CODE};
                `CDSEQ_OFS_OFF:  S_AXI_RDATA <= {24'h000000, OFS_CODE};
                `CDSEQ_SRC_OFF:  S_AXI_RDATA <= {20'h00000, SRC_CODE};
                default: begin
                    S_AXI_RDATA <= 32'h00000000;
                    S_AXI_RRESP <= 2'h2;
                end
            endcase
        end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
        end
    end

    // ==
    // command sequencer
    wire [2:0] op = cmd_q[2:0];
    wire [1:0] ch = cmd_q[5:4];
    wire is_cal = (op == `CDSEQ_CMD_ZERO) || (op == `CDSEQ_CMD_ZALL);
    wire samp_bad = (samp_n < `CDSEQ_SAMP_MIN) || (samp_n > `CDSEQ_SAMP_MAX) ||
                    (rate_n < `CDSEQ_RATE_MIN);
    wire oramp_bad = (arg_q[15:0] == 16'h0000) || (arg_q[15:0] > `CDSEQ_ORAMP_MAX);
    wire sramp_bad = (arg_q[15:0] == 16'h0000) || (arg_q[15:0] > `CDSEQ_SRAMP_MAX);

    always @(posedge CLK_SYS) begin
        samp_start <= 1'b0;
        CONV_LOAD <= 4'h0;
        if (RST) begin
            st_q <= ST_IDLE;
            err_q <= `CDSEQ_ERR_NONE;
            err_rng_q <= 3'h0;
            fail_q <= 6'h00;
            all_q <= 1'b0;
            rng_q <= 3'h0;
            left_q <= 16'h0000;
            done_q <= 1'b0;
            ofs_hold_q <= 8'h80;
            SHORT_EN <= 1'b0;
            CAL_RANGE <= 3'h0;
            CAL_RANGE_OVR <= 1'b0;
            CAL_CHAN <= 2'h0;
            GAIN_CODE <= 8'h00;
            OFS_CODE <= 8'h80;
            SRC_CODE <= 12'h800;      // RULE17
            RELAY_CLOSED <= 1'b1;     // RULE18
        end else begin
            if (INPUT_ENABLE) RELAY_CLOSED <= 1'b1; // RULE18
            case (st_q)
                ST_IDLE: if (cmd_go) begin
                    done_q <= 1'b0;
                    err_q <= `CDSEQ_ERR_NONE;
                    CAL_CHAN <= ch;
                    if (busy || ACQ_ACTIVE) begin
                        err_q <= `CDSEQ_ERR_BUSY;            // RULE19
                    end else if ((is_cal || op == `CDSEQ_CMD_GAIN) && !cal_en_q) begin
                        err_q <= `CDSEQ_ERR_NOCAL;           // RULE3 RULE20
                    end else if (is_cal && samp_bad) begin
                        err_q <= `CDSEQ_ERR_PARAM;           // RULE2
                    end else if (is_cal) begin
                        all_q <= (op == `CDSEQ_CMD_ZALL);    // RULE5
                        fail_q <= 6'h00;
                        rng_q <= (op == `CDSEQ_CMD_ZALL) ? 3'h0 : RANGE_SEL; // RULE1
                        CAL_RANGE <= (op == `CDSEQ_CMD_ZALL) ? 3'h0 : RANGE_SEL;
                        CAL_RANGE_OVR <= 1'b1;
                        SHORT_EN <= 1'b1;                    // RULE1
                        st_q <= ST_ZERO;
                    end else if (op == `CDSEQ_CMD_GAIN) begin
                        GAIN_CODE <= arg_q[7:0];             // RULE9 RULE10
                        OFS_CODE <= ofs_hold_q;              // RULE11
                        CONV_LOAD[ch] <= 1'b1;
                        done_q <= 1'b1;
                    end else if (op == `CDSEQ_CMD_OFS) begin
                        ofs_hold_q <= arg_q[7:0];            // RULE11
                        done_q <= 1'b1;
                    end else if (op == `CDSEQ_CMD_ORAMP) begin
                        if (oramp_bad) err_q <= `CDSEQ_ERR_PARAM; // RULE13
                        else begin
                            left_q <= arg_q[15:0];
                            OFS_CODE <= 8'h00;
                            CONV_LOAD[ch] <= 1'b1;
                            st_q <= ST_ORMP;
                        end
                    end else if (op == `CDSEQ_CMD_SRC) begin
                        SRC_CODE <= arg_q[11:0];             // RULE14
                        RELAY_CLOSED <= 1'b0;                // RULE18
                        done_q <= 1'b1;
                    end else if (op == `CDSEQ_CMD_SRAMP) begin
                        if (sramp_bad) err_q <= `CDSEQ_ERR_PARAM; // RULE16
                        else begin
                            left_q <= arg_q[15:0];
                            SRC_CODE <= 12'h000;
                            RELAY_CLOSED <= 1'b0;
                            st_q <= ST_SRMP;
                        end
                    end else begin
                        err_q <= `CDSEQ_ERR_PARAM;
                    end
                end
                ST_ZERO: begin
                    samp_start <= 1'b1;
                    st_q <= ST_WAIT;
                end
                ST_WAIT: if (samp_done) begin
                    if (samp_fail) begin
                        fail_q[rng_q] <= 1'b1;               // RULE6 RULE7
                        err_q <= `CDSEQ_ERR_RANGE;
                        err_rng_q <= rng_q;                  // RULE8
                    end
                    if (all_q && rng_q != `CDSEQ_NRANGE - 3'h1) begin
                        rng_q <= rng_q + 3'h1;               // RULE5 RULE7
                        CAL_RANGE <= rng_q + 3'h1;
                        st_q <= ST_ZERO;
                    end else begin
                        SHORT_EN <= 1'b0;
                        CAL_RANGE_OVR <= 1'b0;
                        done_q <= 1'b1;
                        st_q <= ST_IDLE;
                    end
                end
                ST_ORMP: if (tick) begin
                    CONV_LOAD[CAL_CHAN] <= 1'b1;
                    if (OFS_CODE != `CDSEQ_OFS_TOP) begin
                        OFS_CODE <= OFS_CODE + 8'h01;        // RULE12
                    end else if (left_q == 16'h0001) begin
                        done_q <= 1'b1;                      // RULE21
                        st_q <= ST_IDLE;
                    end else begin
                        left_q <= left_q - 16'h0001;         // RULE13
                        OFS_CODE <= 8'h00;
                    end
                end
                ST_SRMP: if (tick) begin
                    if (SRC_CODE != `CDSEQ_SRC_TOP) begin
                        SRC_CODE <= SRC_CODE + 12'h001;      // RULE15
                    end else if (left_q == 16'h0001) begin
                        done_q <= 1'b1;                      // RULE21
                        st_q <= ST_IDLE;
                    end else begin
                        left_q <= left_q - 16'h0001;         // RULE16
                        SRC_CODE <= 12'h000;
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// ---- rtl/cdseq_map.vh ----
// Purpose: register offsets, field positions, limits, defaults and timing counts
// Assumes: 32-bit AXI4-Lite register bus, 20 MHz system clock
// Notes:   definitions only
`ifndef CDSEQ_MAP_VH
`define CDSEQ_MAP_VH

// ==
// register byte offsets
`define CDSEQ_CTRL_OFF      8'h00
`define CDSEQ_CMD_OFF       8'h04
`define CDSEQ_ARG_OFF       8'h08
`define CDSEQ_RATE_OFF      8'h0C
`define CDSEQ_STAT_OFF      8'h10
`define CDSEQ_RES_OFF       8'h14
`define CDSEQ_GAIN_OFF      8'h18
`define CDSEQ_OFS_OFF       8'h1C
`define CDSEQ_SRC_OFF       8'h20

// ==
// command codes in CMD[2:0], channel in CMD[5:4]
`define CDSEQ_CMD_ZERO      3'h1
`define CDSEQ_CMD_ZALL      3'h2
`define CDSEQ_CMD_GAIN      3'h3
`define CDSEQ_CMD_OFS       3'h4
`define CDSEQ_CMD_ORAMP     3'h5
`define CDSEQ_CMD_SRC       3'h6
`define CDSEQ_CMD_SRAMP     3'h7

// ==
// error codes in STAT[11:8]
`define CDSEQ_ERR_NONE      4'h0
`define CDSEQ_ERR_NOCAL     4'h1
`define CDSEQ_ERR_BUSY      4'h2
`define CDSEQ_ERR_PARAM     4'h3
`define CDSEQ_ERR_RANGE     4'h4

// ==
// limits and defaults
`define CDSEQ_SAMP_MIN      12'h019
`define CDSEQ_SAMP_MAX      12'hFA0
`define CDSEQ_SAMP_DEF      12'h064
`define CDSEQ_RATE_MIN      23'h000019
`define CDSEQ_RATE_MAX      23'h7FFFFF
`define CDSEQ_RATE_DEF      23'h004E20
`define CDSEQ_ORAMP_MAX     16'h7FFF
`define CDSEQ_SRAMP_MAX     16'h00FF
`define CDSEQ_NRANGE        3'h6
`define CDSEQ_OFS_TOP       8'hFF
`define CDSEQ_SRC_TOP       12'hFFF

// ==
// timing
`define CDSEQ_CLK_HZ        20000000
`define CDSEQ_STEP_US       100
`define CDSEQ_STEP_CYC      ((`CDSEQ_CLK_HZ / 1000000) * `CDSEQ_STEP_US)

`endif

// ---- rtl/cdseq_tick.v ----
// Purpose: step-rate divider for converter ramps
// Assumes: synchronous active-high reset
// Notes:   pulses one cycle every STEP cycles while running
`timescale 1ns/1ps
`default_nettype none
`include "cdseq_map.vh"

module cdseq_tick #(
    parameter STEP = `CDSEQ_STEP_CYC
) (
    input  wire        clk,     // system clock
    input  wire        rst,     // sync reset
    input  wire        run,     // count enable
    output reg         tick     // one-cycle step enable
);
    reg [12:0] cnt_q;

    // ==
    // divider: cleared while idle so the first step is a whole period away
    always @(posedge clk) begin
        if (rst || !run) begin
            cnt_q <= 13'h0000;
            tick  <= 1'b0;
        end else if (cnt_q == STEP[12:0] - 13'h0001) begin
            cnt_q <= 13'h0000;
            tick  <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 13'h0001;
            tick  <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ---- rtl/cdseq_samp.v ----
// Purpose: zero-calibration sample averager for one range
// Assumes: ADC offset sample arrives with a valid strobe
// Notes:   declares a range failed if the mean offset leaves the window
`timescale 1ns/1ps
`default_nettype none
`include "cdseq_map.vh"

module cdseq_samp (
    input  wire        clk,     // system clock
    input  wire        rst,     // sync reset
    input  wire        start,   // begin one range
    input  wire [11:0] samples, // sample count
    input  wire [22:0] rate,    // cycles between samples
    input  wire        adc_vld, // sample valid
    input  wire [15:0] adc_dat, // signed sample under short
    input  wire [15:0] limit,   // tolerated |sum/samples| proxy
    output reg         done,    // one-cycle finish pulse
    output reg         fail     // result with done
);
    reg [22:0] gap_q;
    reg [11:0] left_q;
    reg [27:0] sum_q;
    reg        busy_q;
    wire [27:0] sx = {{12{adc_dat[15]}}, adc_dat};
    wire [27:0] nsum = sum_q + sx;

    // ==
    // take one sample per rate period; mean compared as |sum| <= limit*samples
    always @(posedge clk) begin
        done <= 1'b0;
        if (rst) begin
            busy_q <= 1'b0;
            gap_q  <= 23'h000000;
            left_q <= 12'h000;
            sum_q  <= 28'h0000000;
            fail   <= 1'b0;
        end else if (start) begin
            busy_q <= 1'b1;
            left_q <= samples;
            gap_q  <= 23'h000000;
            sum_q  <= 28'h0000000;
        end else if (busy_q) begin
            if (gap_q != 23'h000000) begin
                gap_q <= gap_q - 23'h000001;
            end else if (adc_vld) begin
                sum_q  <= sum_q + sx;
                gap_q  <= rate;
                left_q <= left_q - 12'h001;
                if (left_q == 12'h001) begin
                    busy_q <= 1'b0;
                    done   <= 1'b1;
                    fail   <= (nsum[27] ? (28'h0000000 - nsum) : nsum)
                              > ({12'h000, limit} * {16'h0000, samples});
                end
            end
        end
    end
endmodule
`default_nettype wire

// ---- bench/cdseq_adc_model.sv ----
// Purpose: offset samples seen through the internal short
// Assumes: one sample every 4 cycles while shorted
// Notes:   ranges set in bad read a large offset
`timescale 1ns/1ps
`default_nettype none
// ==
// sample source
module cdseq_adc_model (
    input  wire logic        clk, // clock
    input  wire logic        rst, // reset
    input  wire logic        sh,  // short on
    input  wire logic [2:0]  rng, // range
    input  wire logic [7:0]  bad, // failing ranges
    output var  logic        vld, // strobe
    output var  logic [15:0] dat  // sample
);
    logic [1:0] cnt_q;
    // data toggles while idle so a stale sample never looks fresh
    always @(posedge clk) begin
        cnt_q <= rst ? 2'h0 : cnt_q + 2'h1;
        vld <= !rst && sh && (cnt_q == 2'h3);
        dat <= rst ? 16'h0 : !sh ? ~dat : bad[rng] ? 16'h0400 : 16'h0001;
    end
endmodule
`default_nettype wire

// ---- bench/cdseq_props.sv ----
// Purpose: port properties of the sequencer
// Assumes: one clock, sync active-high reset
// Notes:   reset checks switch the default disable off
`timescale 1ns/1ps
`default_nettype none
// ==
// checker
module cdseq_props (
    input wire logic        CLK_SYS,      // clock
    input wire logic        RST,          // reset
    input wire logic        S_AXI_BVALID, // answer
    input wire logic        S_AXI_BREADY, // taken
    input wire logic        ACQ_ACTIVE,   // acquiring
    input wire logic        INPUT_ENABLE, // close
    input wire logic        SHORT_EN,     // short
    input wire logic [2:0]  CAL_RANGE,    // range
    input wire logic [1:0]  CAL_CHAN,     // channel
    input wire logic [3:0]  CONV_LOAD,    // load
    input wire logic [11:0] SRC_CODE,     // source
    input wire logic        RELAY_CLOSED  // relay
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    // an answer may not be withdrawn before it is taken
    sequence s_bwait; S_AXI_BVALID && !S_AXI_BREADY; endsequence
    a_bresp_held: assert property (s_bwait |=> S_AXI_BVALID) else $error("answer lost");
    a_src_reset: assert property (disable iff (1'b0) RST |=> SRC_CODE == 12'h800)
        else $error("source not mid-scale");
    a_relay_reset: assert property (disable iff (1'b0) RST |=> RELAY_CLOSED)
        else $error("relay open after reset");
    a_short_reset: assert property (disable iff (1'b0) RST |=> !SHORT_EN)
        else $error("short on after reset");
    a_relay_close: assert property (INPUT_ENABLE |-> ##[1:3] RELAY_CLOSED)
        else $error("relay not closed");
    a_load_ch: assert property (|CONV_LOAD |-> CONV_LOAD == 4'h1 << CAL_CHAN ##1 !CONV_LOAD)
        else $error("bad load strobe");
    a_range_ok: assert property (SHORT_EN |-> CAL_RANGE <= 3'h5)
        else $error("range out of table");
    a_acq_block: assert property ($rose(SHORT_EN) |-> !ACQ_ACTIVE)
        else $error("calibration during acquisition");
endmodule
bind cdseq_top cdseq_props u_props (.*);
`default_nettype wire

// ---- bench/calibration_dac_sequencer_tb_top.sv ----
// Purpose: self-checking bench for the sequencer
// Assumes: the tasks below master the register bus
// Notes:   ramps are timed over one code; a whole ramp runs too long
`timescale 1ns/1ps
`default_nettype none
// ==
// bench
module calibration_dac_sequencer_tb_top;
    logic        clk = 0, rst = 1, aw_v = 0, w_v = 0, ar_v = 0, b_r = 0, r_r = 0;
    logic        acq = 0, ien = 0, aw_y, w_y, ar_y, b_v, r_v, a_v, sh, rly, ovr;
    logic [1:0]  b_s, r_s, rsp, cch;
    logic [2:0]  rsel = 0, crng;
    logic [7:0]  aw_a = 0, ar_a = 0, bad = 0, gn, of, po, ld;
    logic [11:0] src;
    logic [15:0] a_d;
    logic [31:0] w_d = 0, r_d, rdv, g;
    logic [18:0] t [6] = '{{3'h5, 16'h0}, {3'h5, 16'h8000}, {3'h7, 16'h0},
                           {3'h7, 16'h100}, {3'h1, 16'h18}, {3'h1, 16'hFA1}};
    int          n_errors = 0, num_checks = 0, n, i;
    initial forever #25 clk = ~clk;
    cdseq_top DUT (.CLK_SYS(clk), .RST(rst), .S_AXI_AWADDR(aw_a), .S_AXI_AWVALID(aw_v),
        .S_AXI_AWREADY(aw_y), .S_AXI_WDATA(w_d), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(w_v),
        .S_AXI_WREADY(w_y), .S_AXI_BRESP(b_s), .S_AXI_BVALID(b_v), .S_AXI_BREADY(b_r),
        .S_AXI_ARADDR(ar_a), .S_AXI_ARVALID(ar_v), .S_AXI_ARREADY(ar_y), .S_AXI_RDATA(r_d),
        .S_AXI_RRESP(r_s), .S_AXI_RVALID(r_v), .S_AXI_RREADY(r_r), .ACQ_ACTIVE(acq),
        .INPUT_ENABLE(ien), .RANGE_SEL(rsel), .ADC_VALID(a_v), .ADC_DATA(a_d), .SHORT_EN(sh),
        .CAL_RANGE(crng), .CAL_RANGE_OVR(ovr), .CAL_CHAN(cch), .GAIN_CODE(gn), .OFS_CODE(of),
        .CONV_LOAD(ld[3:0]), .SRC_CODE(src), .RELAY_CLOSED(rly));
    cdseq_adc_model u_adc (.clk(clk), .rst(rst), .sh(sh), .rng(crng), .bad(bad),
        .vld(a_v), .dat(a_d));
    task automatic chk(input logic [31:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one bus cycle; each valid drops at the edge that takes it
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {aw_a, ar_a, w_d, aw_v, w_v, ar_v, b_r, r_r} <= {a, a, d, w, w, !w, w, !w};
        do begin
            @(posedge clk);
            {aw_v, w_v, ar_v} <= {aw_v & !aw_y, w_v & !w_y, ar_v & !ar_y};
        end while (!(w ? b_v : r_v));
        {b_r, r_r} <= 2'h0;
        {rsp, rdv} = w ? {b_s, 32'h0} : {r_s, r_d};
    endtask
    task automatic cmd(input logic [2:0] op, input logic [1:0] c, input logic [31:0] arg);
        bus(1, 8'h08, arg);
        bus(1, 8'h04, {26'h0, c, 1'b0, op});
        repeat (4) @(posedge clk);
        bus(0, 8'h10, 0);
    endtask
    task automatic rs();
        rst <= 1;
        repeat (2) @(posedge clk);
        rst <= 0;
        @(posedge clk);
    endtask
    // cycles that code 1 stands on the chosen converter
    task automatic gap(input logic s);
        n = 0;
        while ((s ? src : {4'h0, of}) !== 1) @(posedge clk);
        while ((s ? src : {4'h0, of}) === 1) begin
            @(posedge clk);
            n++;
        end
    endtask
    function automatic logic [2:0] hi(input logic [7:0] m);
        hi = 0;
        for (int k = 0; k < 6; k++) if (m[k]) hi = 3'(k);
    endfunction
    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // watchdog: the run needs about 22k cycles
    initial begin
        repeat (60000) @(posedge clk);
        n_errors++;
        stop_test();
    end
    initial begin
        void'($urandom(32'h01d3eea1));
        rs();
        chk({rly, sh, gn, of, src}, {2'h2, 8'h0, 8'h80, 12'h800});
        cmd(3'h1, 0, 25);
        chk(rdv[11:8], 1);
        cmd(3'h3, 0, 9);
        chk({sh, rdv[11:8]}, 1);
        bus(1, 8'h40, 0);
        chk(rsp, 2);
        bus(0, 8'h40, 0);
        chk({rsp, rdv[29:0]}, 32'h80000000);
        $display("test refusals done");
        bus(1, 8'h00, 32'h400001);
        foreach (t[k]) begin
            cmd(t[k][18:16], 0, t[k][15:0]);
            chk(rdv[11:8], 3);
        end
        po = 8'h80;
        for (i = 0; i < 3; i++) begin
            g = $urandom;
            if (i < 2) g[7:0] = {8{i[0]}};
            cmd(3'h4, g[17:16], g[15:8]);
            chk(of, po);
            cmd(3'h3, g[17:16], g[7:0]);
            chk({gn, of, cch}, {g[7:0], g[15:8], g[17:16]});
            po = g[15:8];
        end
        cmd(3'h6, 0, g[11:0]);
        chk({rly, src}, g[11:0]);
        ien <= 1;
        @(posedge clk);
        ien <= 0;
        repeat (3) @(posedge clk);
        chk(rly, 1);
        acq <= 1;
        cmd(3'h1, 1, 25);
        chk({sh, rdv[11:8]}, 2);
        acq <= 0;
        $display("test converters done");
        bus(1, 8'h0C, 25);
        for (i = 0; i < 3; i++) begin
            bad <= i == 0 ? 8'h21 : i == 1 ? {2'h0, 6'($urandom)} : 8'h0;
            cmd(3'h2, 2, 25);
            do bus(0, 8'h10, 0); while (rdv[0] !== 1'b0);
            bus(0, 8'h14, 0);
            chk(rdv[5:0], bad[5:0]);
            bus(0, 8'h10, 0);
            if (bad != 0) chk(rdv[14:12], hi(bad));
        end
        rsel <= 3'($urandom_range(5));
        cmd(3'h1, 3, 25);
        chk({sh, ovr, crng}, {2'h3, rsel});
        do bus(0, 8'h10, 0); while (rdv[0] !== 1'b0);
        $display("test zero done");
        cmd(3'h5, 1, 1);
        gap(0);
        chk(n, 2000);
        rs();
        cmd(3'h7, 0, 1);
        gap(1);
        chk(n, 2000);
        rs();
        chk(src, 12'h800);
        $display("test ramps done");
        stop_test();
    end
endmodule
`default_nettype wire
